// ### logic/hsq_top.sv
`timescale 1ns/1ps
`include "hsq_defines.svh"
module hsq_top import hsq_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    input wire logic i_go,
    input wire logic i_trig_stop,
    input wire hsq_id_list_t i_seq_ids,
    input wire logic i_effect_done,
    output logic o_playing,
    output logic o_effect_start,
    output logic [6:0] o_effect_id,
    output logic [2:0] o_pass_count,
    output logic o_seq_done,
    input wire logic i_closed_loop,
    input wire logic i_sample_valid,
    input wire logic signed [7:0] i_sample,
    input wire logic signed [7:0] i_wave_max,
    output logic o_seg_valid,
    output logic [1:0] o_seg_kind,
    output logic signed [7:0] o_seg_adjust
);

    hsq_top_st_t st_q;
    hsq_top_st_t st_d;
    hsq_seg_if seg ();
    logic [2:0] repeat_count;
    logic stop_req;
    logic [7:0] slot_used;
    logic endless_mode;
    logic more_passes;

    assign repeat_count = st_q.repeat_ctrl[`HSQ_REPEAT_MSB:`HSQ_REPEAT_LSB];
    assign stop_req = !i_go || i_trig_stop;
    assign endless_mode = (repeat_count == `HSQ_REPEAT_ENDLESS);
    // Counts 1 to 6 give that many extra passes; the same compare ends count 0 after one pass.
    // The issue and wait states share this compare so both end a pass the same way.
    assign more_passes = (st_q.pass < repeat_count);

    // ************************************************************
    // Slot occupancy
    // ************************************************************
    // A slot holding identifier 0 marks the end of the list for this pass.
    for (genvar k = 0; k < `HSQ_SLOT_COUNT; k++) begin : g_slot
        assign slot_used[k] = (i_seq_ids[k] != `HSQ_EMPTY_ID);
    end

    // ************************************************************
    // Register file and sequencer
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.go_prev = i_go;
        st_d.effect_start = 1'b0;
        st_d.seq_done = 1'b0;
        st_d.hit = 1'b0;

        // ************************************************************
        // Register writes
        // ************************************************************
        // Reserved bits of the repeat register are plain storage and read back as written.
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `HSQ_OFS_REPEAT_CTRL: st_d.repeat_ctrl = i_reg_wdata;
                `HSQ_OFS_OD_ADJ: st_d.od_adj = i_reg_wdata;
                `HSQ_OFS_PS_ADJ: st_d.ps_adj = i_reg_wdata;
                `HSQ_OFS_NS_ADJ: st_d.ns_adj = i_reg_wdata;
                default: ;
            endcase
        end

        // ************************************************************
        // Register reads
        // ************************************************************
        // A read alongside a write returns the value from before the write.
        if (i_reg_rd) begin
            st_d.hit = 1'b1;
            unique case (i_reg_addr)
                `HSQ_OFS_REPEAT_CTRL: st_d.rdata = st_q.repeat_ctrl;
                `HSQ_OFS_OD_ADJ: st_d.rdata = st_q.od_adj;
                `HSQ_OFS_PS_ADJ: st_d.rdata = st_q.ps_adj;
                `HSQ_OFS_NS_ADJ: st_d.rdata = st_q.ns_adj;
                default: begin
                    st_d.rdata = 8'h00;
                    st_d.hit = 1'b0;
                end
            endcase
        end

        // ************************************************************
        // Sequencer
        // ************************************************************
        unique case (st_q.state)
            HSQ_IDLE: begin
                st_d.playing = 1'b0;
                // Launch needs a fresh rising edge, so a launch bit left high after the end does not replay.
                if (i_go && !st_q.go_prev && !i_trig_stop) begin
                    st_d.state = HSQ_ISSUE;
                    st_d.slot = 3'h0;
                    st_d.pass = 3'h0;
                    st_d.playing = 1'b1;
                end
            end
            HSQ_ISSUE: begin
                if (stop_req) begin
                    st_d.state = HSQ_IDLE;
                    st_d.playing = 1'b0;
                    st_d.pass = 3'h0;
                end else if (slot_used[st_q.slot]) begin
                    st_d.effect_start = 1'b1;
                    st_d.effect_id = i_seq_ids[st_q.slot];
                    st_d.state = HSQ_WAIT;
                end else if (st_q.slot == 3'h0) begin
                    // An empty first slot would spin forever in the endless mode, so it ends playback.
                    st_d.state = HSQ_IDLE;
                    st_d.playing = 1'b0;
                    st_d.seq_done = 1'b1;
                    st_d.pass = 3'h0;
                end else if (endless_mode) begin
                    // In the endless mode the pass counter is left alone, so it can never wrap.
                    st_d.slot = 3'h0;
                end else if (more_passes) begin
                    st_d.slot = 3'h0;
                    st_d.pass = st_q.pass + 3'h1;
                end else begin
                    st_d.state = HSQ_IDLE;
                    st_d.playing = 1'b0;
                    st_d.seq_done = 1'b1;
                    st_d.pass = 3'h0;
                end
            end
            HSQ_WAIT: begin
                // Stop wins over a finished effect in the same cycle, so a late done never restarts playback.
                if (stop_req) begin
                    st_d.state = HSQ_IDLE;
                    st_d.playing = 1'b0;
                    st_d.pass = 3'h0;
                end else if (i_effect_done) begin
                    st_d.state = HSQ_ISSUE;
                    if (st_q.slot == `HSQ_LAST_SLOT) begin
                        if (endless_mode) begin
                            st_d.slot = 3'h0;
                        end else if (more_passes) begin
                            st_d.slot = 3'h0;
                            st_d.pass = st_q.pass + 3'h1;
                        end else begin
                            st_d.state = HSQ_IDLE;
                            st_d.playing = 1'b0;
                            st_d.seq_done = 1'b1;
                            st_d.pass = 3'h0;
                        end
                    end else begin
                        st_d.slot = st_q.slot + 3'h1;
                    end
                end
            end
            default: begin
                // A corrupted state code drops back to idle rather than driving the player.
                st_d.state = HSQ_IDLE;
                st_d.playing = 1'b0;
                st_d.pass = 3'h0;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
            st_q.repeat_ctrl <= `HSQ_RST_REPEAT_CTRL;
            st_q.od_adj <= `HSQ_RST_ADJ;
            st_q.ps_adj <= `HSQ_RST_ADJ;
            st_q.ns_adj <= `HSQ_RST_ADJ;
            st_q.state <= HSQ_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Waveform segment adjustment
    // ************************************************************
    assign seg.sample_valid = i_sample_valid;
    assign seg.sample = i_sample;
    assign seg.wave_max = i_wave_max;
    assign seg.closed_loop = i_closed_loop;
    assign seg.od_adj = st_q.od_adj;
    assign seg.ps_adj = st_q.ps_adj;
    assign seg.ns_adj = st_q.ns_adj;

    hsq_seg_adjust u_seg (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .seg(seg.classify)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_reg_rdata = st_q.rdata;
    assign o_reg_hit = st_q.hit;
    assign o_playing = st_q.playing;
    assign o_effect_start = st_q.effect_start;
    assign o_effect_id = st_q.effect_id;
    assign o_pass_count = st_q.pass;
    assign o_seq_done = st_q.seq_done;
    assign o_seg_valid = seg.seg_valid;
    assign o_seg_kind = seg.seg_kind;
    assign o_seg_adjust = seg.seg_adjust;

endmodule : hsq_top

// ### logic/hsq_defines.svh
// Behaviour
// - The whole identifier sequence is replayed the number of extra times held in bits 2-0 of register sequence_repeat_ctrl, for counts 1 to 6.
// - Each pass plays the slots in order and ends at the first slot holding identifier 0 or after all eight slots.
// - A repeat count of 0 plays the sequence once with no repeat.
// - A repeat count of 7 repeats without end until the host triggers a stop or clears the launch bit.
// - Register 0x1A lengthens or shortens the overdrive segment of library waveforms.
// - The sample equal to the waveform's maximum voltage, when that maximum is positive, is classed as overdrive without host input.
// - The overdrive adjustment applies only in open loop; in closed loop overdrive is left to the automatic logic.
// - The overdrive adjustment is two's complement and counts in sample step periods.
// - Register 0x1B lengthens or shortens the positive sustain segment of library waveforms.
// - Every positive sample other than the overdrive one is classed as positive sustain.
// - The positive sustain adjustment is two's complement and counts in sample step periods.
// - Register 0x1C lengthens or shortens the negative sustain segment, as a signed count of sample step periods.
`ifndef HSQ_DEFINES_SVH
`define HSQ_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define HSQ_OFS_REPEAT_CTRL 8'h19
`define HSQ_OFS_OD_ADJ 8'h1A
`define HSQ_OFS_PS_ADJ 8'h1B
`define HSQ_OFS_NS_ADJ 8'h1C

// ************************************************************
// Fields and reset values
// ************************************************************
`define HSQ_REPEAT_MSB 2
`define HSQ_REPEAT_LSB 0
`define HSQ_REPEAT_ENDLESS 3'h7
`define HSQ_RST_REPEAT_CTRL 8'h00
`define HSQ_RST_ADJ 8'h00
`define HSQ_SLOT_COUNT 8
`define HSQ_LAST_SLOT 3'h7
`define HSQ_EMPTY_ID 7'h00

`endif

// ### logic/hsq_pkg.sv
package hsq_pkg;

    typedef logic [7:0] hsq_byte_t;
    typedef logic [6:0] hsq_id_t;
    typedef hsq_id_t [7:0] hsq_id_list_t;

    typedef enum logic [1:0] {
        HSQ_IDLE,
        HSQ_ISSUE,
        HSQ_WAIT
    } hsq_state_t;

    typedef enum logic [1:0] {
        HSQ_SEG_NONE,
        HSQ_SEG_OVERDRIVE,
        HSQ_SEG_POS_SUSTAIN,
        HSQ_SEG_NEG_SUSTAIN
    } hsq_seg_t;

    typedef struct packed {
        hsq_byte_t repeat_ctrl;
        hsq_byte_t od_adj;
        hsq_byte_t ps_adj;
        hsq_byte_t ns_adj;
        hsq_byte_t rdata;
        logic hit;
        hsq_state_t state;
        logic [2:0] slot;
        logic [2:0] pass;
        logic go_prev;
        logic playing;
        logic effect_start;
        hsq_id_t effect_id;
        logic seq_done;
    } hsq_top_st_t;

    typedef struct packed {
        logic valid;
        hsq_seg_t kind;
        logic signed [7:0] adjust;
    } hsq_seg_st_t;

endpackage : hsq_pkg

// ### logic/hsq_seg_if.sv
`timescale 1ns/1ps
interface hsq_seg_if;
    import hsq_pkg::*;
    logic sample_valid;
    logic signed [7:0] sample;
    logic signed [7:0] wave_max;
    logic closed_loop;
    hsq_byte_t od_adj;
    hsq_byte_t ps_adj;
    hsq_byte_t ns_adj;
    logic seg_valid;
    hsq_seg_t seg_kind;
    logic signed [7:0] seg_adjust;

    modport ctrl (
        output sample_valid, sample, wave_max, closed_loop, od_adj, ps_adj, ns_adj,
        input seg_valid, seg_kind, seg_adjust
    );
    modport classify (
        input sample_valid, sample, wave_max, closed_loop, od_adj, ps_adj, ns_adj,
        output seg_valid, seg_kind, seg_adjust
    );
endinterface : hsq_seg_if

// ### logic/hsq_seg_adjust.sv
`timescale 1ns/1ps
`include "hsq_defines.svh"
module hsq_seg_adjust import hsq_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_nrst,
    hsq_seg_if.classify seg
);

    hsq_seg_st_t st_q;
    hsq_seg_st_t st_d;

    // ************************************************************
    // Segment classification
    // ************************************************************
    // The adjustment is a signed count of sample step periods; the waveform player adds it to the segment length.
    always_comb begin
        st_d = st_q;
        st_d.valid = seg.sample_valid;
        if (seg.sample_valid) begin
            if (seg.sample == seg.wave_max && seg.sample > 8'sh00) begin
                st_d.kind = HSQ_SEG_OVERDRIVE;
                // Closed loop sizes overdrive from feedback, so the host offset is held off.
                st_d.adjust = seg.closed_loop ? 8'sh00 : $signed(seg.od_adj);
            end else if (seg.sample > 8'sh00) begin
                st_d.kind = HSQ_SEG_POS_SUSTAIN;
                st_d.adjust = $signed(seg.ps_adj);
            end else if (seg.sample < 8'sh00) begin
                st_d.kind = HSQ_SEG_NEG_SUSTAIN;
                st_d.adjust = $signed(seg.ns_adj);
            end else begin
                st_d.kind = HSQ_SEG_NONE;
                st_d.adjust = 8'sh00;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign seg.seg_valid = st_q.valid;
    assign seg.seg_kind = st_q.kind;
    assign seg.seg_adjust = st_q.adjust;

endmodule : hsq_seg_adjust

// ### dv/hsq_fx_model.sv
`timescale 1ns/1ps
// ************************************************************
// Effect player stand-in: answers each start after a set delay
// ************************************************************
module hsq_fx_model (
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic [3:0] i_delay,
    output logic o_done = 1'h0
);
    logic [4:0] cnt_q = 5'h00;
    always @(posedge i_mclk) begin
        o_done <= 1'h0;
        if (i_start) begin
            cnt_q <= {1'h0, i_delay} + 5'h01;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
            o_done <= (cnt_q == 5'h01);
        end
    end
endmodule : hsq_fx_model

// ### dv/hsq_top_sva.sv
`timescale 1ns/1ps
module hsq_top_sva (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_hit,
    input wire logic i_go,
    input wire logic i_trig_stop,
    input wire logic [55:0] i_seq_ids,
    input wire logic i_effect_done,
    input wire logic o_playing,
    input wire logic o_effect_start,
    input wire logic [2:0] o_pass_count,
    input wire logic o_seq_done,
    input wire logic i_closed_loop,
    input wire logic i_sample_valid,
    input wire logic signed [7:0] i_sample,
    input wire logic signed [7:0] i_wave_max,
    input wire logic o_seg_valid,
    input wire logic [1:0] o_seg_kind,
    input wire logic signed [7:0] o_seg_adjust
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic rd_map;
    assign rd_map = i_reg_rd && i_reg_addr >= 8'h19 && i_reg_addr <= 8'h1C;
    sequence s_wr_rd;
        i_reg_wr && !i_reg_rd ##1 rd_map && !i_reg_wr && i_reg_addr == $past(i_reg_addr);
    endsequence
    sequence s_launch;
        i_go && !$past(i_go) && !i_trig_stop && !o_playing;
    endsequence
    sequence s_launch_kept;
        s_launch ##1 i_go && !i_trig_stop && i_seq_ids[6:0] != 7'h00;
    endsequence
    sequence s_effect_over;
        i_effect_done && o_playing && i_go && !i_trig_stop;
    endsequence
    a_hit_mapped: assert property (rd_map |=> o_reg_hit) else $error("hit missing");
    a_hit_unmapped: assert property (!rd_map |=> !o_reg_hit) else $error("stray hit");
    a_write_readback: assert property (s_wr_rd |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("readback wrong");
    a_launch_start: assert property (s_launch_kept |-> o_playing ##1 o_effect_start)
        else $error("launch wrong");
    a_stop_clears: assert property (o_playing && (!i_go || i_trig_stop) |=> !o_playing && o_pass_count == 3'h0
        && !o_seq_done) else $error("stop wrong");
    a_next_step: assert property (s_effect_over |-> ##[1:3] (o_effect_start || o_seq_done || !i_go || i_trig_stop))
        else $error("next step wrong");
    a_done_idle: assert property (o_seq_done |-> !o_playing && o_pass_count == 3'h0)
        else $error("done while busy");
    a_seg_pulse: assert property (i_sample_valid |=> o_seg_valid) else $error("seg late");
    a_seg_quiet: assert property (!i_sample_valid |=> !o_seg_valid) else $error("seg stray");
    a_seg_closed: assert property (i_sample_valid && i_closed_loop && i_sample == i_wave_max && i_sample > 0
        |=> o_seg_kind == 2'h1 && o_seg_adjust == 8'h00) else $error("closed od wrong");
    a_seg_neg: assert property (i_sample_valid && i_sample < 0 |=> o_seg_kind == 2'h3)
        else $error("neg kind wrong");
endmodule : hsq_top_sva
bind hsq_top hsq_top_sva u_sva (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .i_go(i_go), .i_trig_stop(i_trig_stop), .i_seq_ids(i_seq_ids), .i_effect_done(i_effect_done),
    .o_playing(o_playing), .o_effect_start(o_effect_start), .o_pass_count(o_pass_count),
    .o_seq_done(o_seq_done), .i_closed_loop(i_closed_loop), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .i_wave_max(i_wave_max), .o_seg_valid(o_seg_valid), .o_seg_kind(o_seg_kind),
    .o_seg_adjust(o_seg_adjust)
);

// ### dv/haptic_sequence_loop_timing_regs_tb.sv
`timescale 1ns/1ps
module haptic_sequence_loop_timing_regs_tb;
    import hsq_pkg::*;
    logic i_mclk = 1'h0, i_nrst = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_go = 1'h0, i_trig_stop = 1'h0;
    logic i_closed_loop = 1'h0, i_sample_valid = 1'h0, i_effect_done;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, starts = 8'h00;
    logic signed [7:0] i_sample = 8'h00, i_wave_max = 8'h00, o_seg_adjust;
    hsq_id_list_t i_seq_ids = '0;
    logic o_reg_hit, o_playing, o_effect_start, o_seq_done, o_seg_valid;
    logic [6:0] o_effect_id;
    logic [2:0] o_pass_count;
    logic [1:0] o_seg_kind;
    logic [3:0] fx_delay = 4'h0;
    logic [11:0] exp_q[$];
    logic [7:0] regs[4] = '{default: 8'h00};
    integer seed = 32'h9218, r, num_errors = 0, total_checks = 0;
    int seq_len = 1;
    logic [2:0] exp_pass;
    always #10 i_mclk = ~i_mclk;
    hsq_top uut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
        .i_go(i_go), .i_trig_stop(i_trig_stop), .i_seq_ids(i_seq_ids), .i_effect_done(i_effect_done),
        .o_playing(o_playing), .o_effect_start(o_effect_start), .o_effect_id(o_effect_id),
        .o_pass_count(o_pass_count), .o_seq_done(o_seq_done), .i_closed_loop(i_closed_loop),
        .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_wave_max(i_wave_max),
        .o_seg_valid(o_seg_valid), .o_seg_kind(o_seg_kind), .o_seg_adjust(o_seg_adjust)
    );
    hsq_fx_model u_fx (.i_mclk(i_mclk), .i_start(o_effect_start), .i_delay(fx_delay), .o_done(i_effect_done));
    // ************************************************************
    // Checking
    // ************************************************************
    task summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task chk(input string n, input logic [11:0] e, input logic [11:0] s);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task pop(input string n, input logic [11:0] s);
        // An empty queue means the design produced a result nobody asked for.
        chk(n, (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF, s);
    endtask : pop
    always @(posedge i_mclk) begin
        #1;
        if (o_reg_hit === 1'h1) pop("rdata", {4'h1, o_reg_rdata});
        if (o_seg_valid === 1'h1) pop("seg", {2'h2, o_seg_kind, o_seg_adjust});
        if (o_effect_start === 1'h1) begin
            chk("effect_id", {5'h00, i_seq_ids[starts % seq_len]}, {5'h00, o_effect_id});
            exp_pass = (regs[0][2:0] == 3'h7) ? 3'h0 : 3'(starts / seq_len);
            chk("pass", {9'h000, exp_pass}, {9'h000, o_pass_count});
            starts++;
        end
        if (o_seq_done === 1'h1) pop("starts", {4'h3, starts});
    end
    // ************************************************************
    // Stimulus
    // ************************************************************
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'h1};
        if (a >= 8'h19 && a <= 8'h1C) regs[a - 8'h19] = d;
        @(negedge i_mclk);
        i_reg_wr = 1'h0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(negedge i_mclk);
        {i_reg_addr, i_reg_rd} = {a, 1'h1};
        if (a >= 8'h19 && a <= 8'h1C) exp_q.push_back({4'h1, regs[a - 8'h19]});
        @(negedge i_mclk);
        i_reg_rd = 1'h0;
        if (a < 8'h19 || a > 8'h1C) chk("unmapped", 12'h000, {4'h0, o_reg_rdata});
    endtask : rd
    task play(input int n);
        int w;
        r = $random(seed);
        seq_len = r[2:0] + 1;
        wr(8'h19, {r[7:3], n[2:0]});
        for (int k = 0; k < 8; k++) i_seq_ids[k] = (k < seq_len) ? (7'(r >> k) | 7'h01) : 7'h00;
        fx_delay = r[13:10];
        starts = 8'h00;
        if (n != 7) begin
            exp_q.push_back({4'h3, 8'((n + 1) * seq_len)});
            @(negedge i_mclk) i_go = 1'h1;
            repeat (2) @(negedge i_mclk);
            for (w = 0; w < 3000 && o_playing === 1'h1; w++) @(negedge i_mclk);
            i_go = 1'h0;
        end else begin
            for (int j = 0; j < 2; j++) begin
                @(negedge i_mclk) i_go = 1'h1;
                starts = 8'h00;
                repeat (300) @(negedge i_mclk);
                chk("endless", 12'h008, {8'h00, o_playing, o_pass_count});
                {i_trig_stop, i_go} = {j == 0, j == 0};
                @(negedge i_mclk) {i_trig_stop, i_go} = 2'h0;
                chk("stopped", 12'h000, {8'h00, o_playing, o_pass_count});
            end
        end
        @(negedge i_mclk);
    endtask : play
    initial begin
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk) i_nrst = 1'h1;
        for (int a = 8'h18; a <= 8'h1D; a++) rd(a[7:0]);
        for (int a = 8'h19; a <= 8'h1C; a++) begin
            r = $random(seed);
            wr(a[7:0], r[7:0]);
            rd(a[7:0]);
            // Write and read back in adjacent cycles so the readback assertion sees real traffic.
            @(negedge i_mclk);
            {i_reg_addr, i_reg_wdata, i_reg_wr} = {a[7:0], r[15:8], 1'h1};
            regs[a - 8'h19] = r[15:8];
            @(negedge i_mclk);
            {i_reg_wr, i_reg_rd} = 2'h1;
            exp_q.push_back({4'h1, r[15:8]});
            @(negedge i_mclk) i_reg_rd = 1'h0;
        end
        repeat (64) begin
            @(negedge i_mclk);
            r = $random(seed);
            {i_sample_valid, i_sample, i_closed_loop} = {1'h1, r[7:0], r[8]};
            i_wave_max = r[9] ? r[7:0] : r[17:10];
            if (i_sample == i_wave_max && i_sample > 0) exp_q.push_back({4'h9, i_closed_loop ? 8'h00 : regs[1]});
            else if (i_sample > 0) exp_q.push_back({4'hA, regs[2]});
            else if (i_sample < 0) exp_q.push_back({4'hB, regs[3]});
            else exp_q.push_back(12'h800);
        end
        @(negedge i_mclk) i_sample_valid = 1'h0;
        for (int n = 0; n < 8; n++) play(n);
        repeat (4) @(negedge i_mclk);
        chk("pending", 12'h000, 12'(exp_q.size()));
        summarize();
    end
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end
endmodule : haptic_sequence_loop_timing_regs_tb
